//--- core/ring_perf_event_select.sv
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module ring_perf_event_select (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] upperAgentAdCreditExhausted,
	input wire logic [7:0] lowerAgentAdCreditExhausted,
	input wire logic [3:0] homeBridgeBlCreditExhaustedLower,
	input wire logic [3:0] homeBridgeBlCreditExhaustedUpper,
	input wire logic [6:0] link0AdCreditExhausted,
	input wire logic [6:0] link0BlCreditExhausted,
	input wire logic [6:0] link1AdCreditExhausted,
	input wire logic [6:0] link1BlCreditExhausted,
	input wire logic [3:0] adRingBusy,
	input wire logic [3:0] ackRingBusy,
	input wire logic [3:0] blockRingBusy,
	input wire logic [3:0] invalidateRingBusy,
	input wire logic [2:0] ringStarved,
	output logic [1:0] counterIncrement0,
	output logic [1:0] counterIncrement1,
	output logic [1:0] counterIncrement2
);
	typedef struct packed {
		logic [ring_perf_pkg::NumCounters-1:0][ring_perf_pkg::CtlWidth-1:0] ctl;
		logic [ring_perf_pkg::NumCounters-1:0][ring_perf_pkg::IncWidth-1:0] inc;
		logic [31:0] rdata;
		logic err;
	} state_s;

	state_s state_r;
	state_s state_nxt;
	logic [ring_perf_pkg::NumCounters-1:0][ring_perf_pkg::IncWidth-1:0] incRaw;

	// Per-counter decode of the selected event into this cycle's increment
	for (genvar c = 0; c < ring_perf_pkg::NumCounters; c++) begin : gCounter
		logic [7:0] evCode;
		logic [7:0] subMask;
		logic [3:0] homeBridgeSrc;
		logic [2:0] starvedSel;
		logic creditAllowed;
		logic [1:0] inc;
		always_comb begin
			evCode = state_r.ctl[c][ring_perf_pkg::EventLsb +: ring_perf_pkg::FieldWidth];
			subMask = state_r.ctl[c][ring_perf_pkg::UmaskLsb +: ring_perf_pkg::FieldWidth];
			// Credit events only exist on counters 0 and 1
			creditAllowed = (c <= ring_perf_pkg::CreditCounterLimit);
			homeBridgeSrc = (c == 0) ? homeBridgeBlCreditExhaustedLower
				: homeBridgeBlCreditExhaustedUpper;
			starvedSel = ringStarved & subMask[2:0];
			inc = ring_perf_pkg::IncZero;
			unique case (evCode)
				ring_perf_pkg::EvClockTick: begin
					inc = ring_perf_pkg::IncOne;
				end
				ring_perf_pkg::EvAdRingBusy: begin
					inc = {1'b0, |(adRingBusy & subMask[3:0])};
				end
				ring_perf_pkg::EvAckRingBusy: begin
					inc = {1'b0, |(ackRingBusy & subMask[3:0])};
				end
				ring_perf_pkg::EvBlockRingBusy: begin
					inc = {1'b0, |(blockRingBusy & subMask[3:0])};
				end
				ring_perf_pkg::EvInvalidateRingBusy: begin
					// Half-packets per direction fold into one busy cycle
					inc = {1'b0, |(invalidateRingBusy & subMask[3:0])};
				end
				ring_perf_pkg::EvRingStarved: begin
					// Three rings may starve at once; saturate at two
					if (starvedSel == 3'h7) begin
						inc = ring_perf_pkg::IncMaxStarve;
					end else begin
						inc = 2'(starvedSel[0]) + 2'(starvedSel[1]) + 2'(starvedSel[2]);
					end
				end
				ring_perf_pkg::EvUpperAgentAd: begin
					inc = {1'b0, creditAllowed & |(upperAgentAdCreditExhausted & subMask)};
				end
				ring_perf_pkg::EvLowerAgentAd: begin
					inc = {1'b0, creditAllowed & |(lowerAgentAdCreditExhausted & subMask)};
				end
				ring_perf_pkg::EvHomeBridgeBl: begin
					inc = {1'b0, creditAllowed & |(homeBridgeSrc & subMask[3:0])};
				end
				ring_perf_pkg::EvLink0Ad: begin
					inc = {1'b0, creditAllowed
						& |({1'b0, link0AdCreditExhausted} & subMask & ring_perf_pkg::LinkAllMask)};
				end
				ring_perf_pkg::EvLink0Bl: begin
					inc = {1'b0, creditAllowed
						& |({1'b0, link0BlCreditExhausted} & subMask
						& ring_perf_pkg::LinkPoolNetOneMask)};
				end
				ring_perf_pkg::EvLink1Ad: begin
					inc = {1'b0, creditAllowed
						& |({1'b0, link1AdCreditExhausted} & subMask
						& ring_perf_pkg::LinkPoolNetOneMask)};
				end
				ring_perf_pkg::EvLink1Bl: begin
					inc = {1'b0, creditAllowed
						& |({1'b0, link1BlCreditExhausted} & subMask & ring_perf_pkg::LinkAllMask)};
				end
				default: begin
					inc = ring_perf_pkg::IncZero;
				end
			endcase
		end
		assign incRaw[c] = inc;
	end

	logic setupPhase;
	logic [1:0] ctlHit;
	logic ctlValid;
	logic statusHit;

	always_comb begin
		state_nxt = state_r;
		setupPhase = psel && !penable;
		ctlHit = 2'h0;
		ctlValid = 1'b1;
		statusHit = 1'b0;
		unique case (paddr)
			ring_perf_pkg::OffCtl0: begin
				ctlHit = 2'h0;
			end
			ring_perf_pkg::OffCtl1: begin
				ctlHit = 2'h1;
			end
			ring_perf_pkg::OffCtl2: begin
				ctlHit = 2'h2;
			end
			ring_perf_pkg::OffIncStatus: begin
				ctlValid = 1'b0;
				statusHit = 1'b1;
			end
			default: begin
				ctlValid = 1'b0;
			end
		endcase
		// One registered stage: counts trail the sources by a cycle, as ticks do globally
		state_nxt.inc = incRaw;
		if (setupPhase) begin
			state_nxt.err = !(ctlValid || (statusHit && !pwrite));
			state_nxt.rdata = 32'h0000_0000;
			if (ctlValid && !pwrite) begin
				state_nxt.rdata = {16'h0000, state_r.ctl[ctlHit]};
			end else if (statusHit && !pwrite) begin
				state_nxt.rdata = {26'h0, state_r.inc[2], state_r.inc[1], state_r.inc[0]};
			end
		end
		// Write takes effect on the completing access edge
		if (psel && penable && pwrite && ctlValid) begin
			if (pstrb[0]) begin
				state_nxt.ctl[ctlHit][ring_perf_pkg::EventLsb +: ring_perf_pkg::FieldWidth] =
					pwdata[ring_perf_pkg::EventLsb +: ring_perf_pkg::FieldWidth];
			end
			if (pstrb[1]) begin
				state_nxt.ctl[ctlHit][ring_perf_pkg::UmaskLsb +: ring_perf_pkg::FieldWidth] =
					pwdata[ring_perf_pkg::UmaskLsb +: ring_perf_pkg::FieldWidth];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r.ctl <= {ring_perf_pkg::NumCounters{ring_perf_pkg::CtlReset}};
			state_r.inc <= '0;
			state_r.rdata <= 32'h0000_0000;
			state_r.err <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Zero-wait slave: data was captured in the setup cycle
	assign pready = psel && penable;
	assign pslverr = psel && penable && state_r.err;
	assign prdata = state_r.rdata;
	assign counterIncrement0 = state_r.inc[0];
	assign counterIncrement1 = state_r.inc[1];
	assign counterIncrement2 = state_r.inc[2];
endmodule // ring_perf_event_select

//--- core/ring_perf_pkg.sv
// Operation
// - Code 01 adds one every uncore clock cycle on counters 0 to 2
// - Tick count may lag the global count by a few cycles
// - Code 1f counts no AD credits toward agents 8 to 15 per mask
// - Code 22 counts no AD credits toward agents 0 to 7 per mask
// - Code 2d counts no BL credits toward home agents or bridge classes
// - For code 2d counter 0 sees lower agents, counter 1 higher agents
// - Code 20 counts no AD credits toward link 0 per pool and class
// - Code 21 counts no BL credits toward link 0, pool and network one
// - Code 2e counts no AD credits toward link 1, pool and network one
// - Code 2f counts no BL credits toward link 1 per pool and class
// - Credit events live on counters 0 and 1, adding at most one
// - Code 07 counts AD ring occupied by passing or sunk packets
// - Code 08 counts AK ring occupied by passing or sunk packets
// - Code 09 counts BL ring occupied by passing or sunk packets
// - Code 0a counts IV ring occupied by passing or sent packets
// - Ring mask bits pick clockwise even, odd, counterclockwise even, odd
// - At most one packet per direction per ring seen each cycle
// - IV messages travel as halves, one half per direction per cycle
// - Code 0e counts starved cycles per ring, up to two per cycle
// - Control bits 7:0 select the event code of each counter
// - Control bits 15:8 select the sub-events that contribute
package ring_perf_pkg;
	localparam int NumCounters = 3;
	localparam int CtlWidth = 16;
	localparam int IncWidth = 2;
	localparam int RingBits = 4;
	localparam int StarveRings = 3;

	localparam logic [11:0] OffCtl0 = 12'h0d8;
	localparam logic [11:0] OffCtl1 = 12'h0dc;
	localparam logic [11:0] OffCtl2 = 12'h0e0;
	localparam logic [11:0] OffIncStatus = 12'h0e4;

	localparam int EventLsb = 0;
	localparam int UmaskLsb = 8;
	localparam int FieldWidth = 8;
	localparam logic [15:0] CtlReset = 16'h0000;
	localparam logic [1:0] IncZero = 2'h0;
	localparam logic [1:0] IncOne = 2'h1;
	localparam logic [1:0] IncMaxStarve = 2'h2;

	localparam logic [7:0] EvClockTick = 8'h01;
	localparam logic [7:0] EvAdRingBusy = 8'h07;
	localparam logic [7:0] EvAckRingBusy = 8'h08;
	localparam logic [7:0] EvBlockRingBusy = 8'h09;
	localparam logic [7:0] EvInvalidateRingBusy = 8'h0a;
	localparam logic [7:0] EvRingStarved = 8'h0e;
	localparam logic [7:0] EvUpperAgentAd = 8'h1f;
	localparam logic [7:0] EvLink0Ad = 8'h20;
	localparam logic [7:0] EvLink0Bl = 8'h21;
	localparam logic [7:0] EvLowerAgentAd = 8'h22;
	localparam logic [7:0] EvHomeBridgeBl = 8'h2d;
	localparam logic [7:0] EvLink1Ad = 8'h2e;
	localparam logic [7:0] EvLink1Bl = 8'h2f;

	// Reduced links only carry the pool and network one classes
	localparam logic [7:0] LinkPoolNetOneMask = 8'h71;
	localparam logic [7:0] LinkAllMask = 8'h7f;
	localparam logic [7:0] HomeBridgeMask = 8'h0f;
	localparam logic [7:0] RingDirMask = 8'h0f;
	localparam logic [7:0] StarveMask = 8'h07;
	localparam int CreditCounterLimit = 1;
endpackage

//--- tb/ring_perf_event_select_properties.sv
`timescale 1ns/100ps
module ring_perf_event_select_properties (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] counterIncrement0,
	input wire logic [1:0] counterIncrement2
);
	logic [7:0] ev0_r;
	logic [7:0] ev2_r;
	logic wr, cr0, cr2, rg0;
	assign wr = psel && penable && pwrite && pstrb[0];
	assign cr0 = ev0_r inside {8'h1f, 8'h20, 8'h21, 8'h22, 8'h2d, 8'h2e, 8'h2f};
	assign cr2 = ev2_r inside {8'h1f, 8'h20, 8'h21, 8'h22, 8'h2d, 8'h2e, 8'h2f};
	assign rg0 = ev0_r inside {[8'h07:8'h0a]};
	// Shadow of the event fields of counters 0 and 2, so outputs can be tied to the code in force
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ev0_r <= 8'h00;
			ev2_r <= 8'h00;
		end else begin
			if (wr && paddr == 12'h0d8) ev0_r <= pwdata[7:0];
			if (wr && paddr == 12'h0e0) ev2_r <= pwdata[7:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_ready; pready == (psel && penable); endproperty
	property p_tick; $past(ev0_r) == 8'h01 |-> counterIncrement0 == 2'h1; endproperty
	property p_idle; $past(ev0_r) == 8'h00 |-> counterIncrement0 == 2'h0; endproperty
	property p_cr2; $past(cr2) |-> counterIncrement2 == 2'h0; endproperty
	property p_cr0; $past(cr0) |-> counterIncrement0 <= 2'h1; endproperty
	property p_ring; $past(rg0) |-> counterIncrement0 <= 2'h1; endproperty
	property p_starve; counterIncrement2 != 2'h3; endproperty
	property p_ro; psel && penable && pwrite && paddr == 12'h0e4 |-> pslverr; endproperty
	a_ready: assert property (p_ready) else $error("ready wrong");
	a_tick: assert property (p_tick) else $error("tick wrong");
	a_idle: assert property (p_idle) else $error("idle code counts");
	a_cr2: assert property (p_cr2) else $error("credit on counter 2");
	a_cr0: assert property (p_cr0) else $error("credit above one");
	a_ring: assert property (p_ring) else $error("ring above one");
	a_starve: assert property (p_starve) else $error("starve above two");
	a_ro: assert property (p_ro) else $error("status write accepted");
	cover property ($past(ev0_r) == 8'h0e && counterIncrement0 == 2'h2);
	cover property ($past(cr0) && counterIncrement0 == 2'h1);
	cover property (pslverr);
endmodule // ring_perf_event_select_properties
bind ring_perf_event_select ring_perf_event_select_properties ring_perf_event_select_properties_inst (
	.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
	.counterIncrement0(counterIncrement0), .counterIncrement2(counterIncrement2));

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
	logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, seed = 32'h00012eca;
	logic [31:0] x;
	logic [3:0] pstrb = 0, hbLo = 0, hbHi = 0, adB = 0, akB = 0, blB = 0, ivB = 0, strb = 4'hf;
	logic [7:0] upAd = 0, loAd = 0;
	logic [6:0] l0Ad = 0, l0Bl = 0, l1Ad = 0, l1Bl = 0;
	logic [2:0] starve = 0;
	logic [1:0] inc0, inc1, inc2;
	logic [15:0] ctl[3];
	logic [7:0] codes[15] = '{8'h01, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0e, 8'h1f, 8'h20,
		8'h21, 8'h22, 8'h2d, 8'h2e, 8'h2f, 8'h00, 8'h3c};
	int errTotal = 0, checked = 0, cycles = 0;
	always #5 clock = ~clock;
	ring_perf_event_select ring_perf_event_select_inst (.clock(clock), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.upperAgentAdCreditExhausted(upAd), .lowerAgentAdCreditExhausted(loAd),
		.homeBridgeBlCreditExhaustedLower(hbLo), .homeBridgeBlCreditExhaustedUpper(hbHi),
		.link0AdCreditExhausted(l0Ad), .link0BlCreditExhausted(l0Bl),
		.link1AdCreditExhausted(l1Ad), .link1BlCreditExhausted(l1Bl), .adRingBusy(adB),
		.ackRingBusy(akB), .blockRingBusy(blB), .invalidateRingBusy(ivB),
		.ringStarved(starve), .counterIncrement0(inc0), .counterIncrement1(inc1),
		.counterIncrement2(inc2));
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic [1:0] expInc(input logic [15:0] c, input int n);
		logic [7:0] m;
		logic [2:0] s;
		m = c[15:8];
		s = starve & m[2:0];
		case (c[7:0])
			8'h01: return 2'h1;
			8'h07: return {1'b0, |(adB & m[3:0])};
			8'h08: return {1'b0, |(akB & m[3:0])};
			8'h09: return {1'b0, |(blB & m[3:0])};
			8'h0a: return {1'b0, |(ivB & m[3:0])};
			8'h0e: return (s[0] + s[1] + s[2] > 1) ? 2'h2 : {1'b0, |s};
			default: ;
		endcase
		// Credit events are not offered on the third counter
		if (n == 2) return 2'h0;
		case (c[7:0])
			8'h1f: return {1'b0, |(upAd & m)};
			8'h22: return {1'b0, |(loAd & m)};
			8'h2d: return {1'b0, |((n == 0 ? hbLo : hbHi) & m[3:0])};
			8'h20: return {1'b0, |(l0Ad & m[6:0])};
			8'h21: return {1'b0, |(l0Bl & m[6:0] & 7'h71)};
			8'h2e: return {1'b0, |(l1Ad & m[6:0] & 7'h71)};
			8'h2f: return {1'b0, |(l1Bl & m[6:0])};
			default: return 2'h0;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errTotal++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, strb};
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Mode 1 clears all events, mode 2 raises all but the ring-busy inputs (a ^ b clears them), else random
	task automatic drive(input logic [1:0] md);
		logic [31:0] a, b;
		a = md == 1 ? 0 : md == 2 ? '1 : rnd();
		b = md == 1 ? 0 : md == 2 ? '1 : rnd();
		@(posedge clock);
		{upAd, loAd, hbLo, hbHi, l0Ad} <= a[30:0];
		{l0Bl, l1Ad, l1Bl, starve} <= b[23:0];
		{adB, akB, blB, ivB} <= a[31:16] ^ b[31:16];
		repeat (2) @(posedge clock);
	endtask
	task automatic testDone();
		$display("checks %0d mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			errTotal++;
			testDone();
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		rst <= 0;
		apb(0, 12'h0d8, 0);
		chk(q, 0);
		apb(0, 12'h0f0, 0);
		chk({e, q[30:0]}, 32'h80000000);
		apb(1, 12'h0e4, 32'h0000ffff);
		chk(e, 1);
		// Byte lanes: low lane holds the event, next lane the sub-event mask
		apb(1, 12'h0e0, 32'h0000_1234);
		strb = 4'h1;
		apb(1, 12'h0e0, 32'h0000_abcd);
		strb = 4'h2;
		apb(1, 12'h0e0, 32'h0000_5600);
		strb = 4'hf;
		apb(0, 12'h0e0, 0);
		chk(q, 32'h0000_56cd);
		$display("test registers done");
		foreach (codes[i]) begin
			for (int n = 0; n < 3; n++) begin
				ctl[n] = {i[0] ? 8'hff : 8'(rnd()), codes[i]};
				apb(1, 12'h0d8 + 12'(4 * n), {16'h0, ctl[n]});
			end
			apb(0, 12'h0dc, 0);
			chk(q, {16'h0, ctl[1]});
			for (int k = 0; k < 12; k++) begin
				drive(2'(k % 3));
				x = {26'h0, expInc(ctl[2], 2), expInc(ctl[1], 1), expInc(ctl[0], 0)};
				chk({26'h0, inc2, inc1, inc0}, x);
			end
			apb(0, 12'h0e4, 0);
			chk(q, {26'h0, expInc(ctl[2], 2), expInc(ctl[1], 1), expInc(ctl[0], 0)});
			$display("test code %h done", codes[i]);
		end
		testDone();
	end
endmodule // tb
